// File: rtl/sim_lowpower_defs.vh
`ifndef SIM_LOWPOWER_DEFS_VH
`define SIM_LOWPOWER_DEFS_VH
`define ADDR_BREAK_STATUS       16'hfe00
`define ADDR_RESET_SOURCE       16'hfe01
`define ADDR_BREAK_FLAG_CONTROL 16'hfe03
`define BIT_BREAK_EXITED        1
`define BIT_RST_POWER_ON        7
`define BIT_RST_PIN             6
`define BIT_RST_WATCHDOG        4
`define BIT_RST_ILLEGAL_OPCODE  3
`define BIT_RST_ILLEGAL_ADDR    2
`define BIT_RST_LOW_VOLTAGE     1
`define BIT_BREAK_CLEAR_ENABLE  7
`define RESET_BYTE              8'h00
`define POR_RESET_BYTE          8'h80
`define SWI_VECTOR_ADDR         16'hfffc
`define RECOVERY_LONG_CYCLES    13'h1000
`define RECOVERY_SHORT_CYCLES   13'h0020
`endif

// File: rtl/recovery_counter.v
`timescale 1ns/1ns
`include "sim_lowpower_defs.vh"
module recovery_counter (
  input  wire       clock,
  input  wire       rstn,
  input  wire       hold,
  input  wire       xclk_tick,
  input  wire       short_sel,
  output reg        done
);
  reg  [12:0] count_reg;
  wire [12:0] target;
  assign target = short_sel ? `RECOVERY_SHORT_CYCLES : `RECOVERY_LONG_CYCLES;
  always @(posedge clock) begin
    if (!rstn || hold) begin
      count_reg <= 13'h0000;
      done      <= 1'b0;
    end else if (xclk_tick && !done) begin
      count_reg <= count_reg + 13'h0001;
      done      <= (count_reg + 13'h0001) == target;
    end
  end
endmodule

// File: rtl/flag_guard.v
`timescale 1ns/1ns
module flag_guard (
  input  wire       clock,
  input  wire       rstn,
  input  wire       in_break,
  input  wire       clear_enable,
  output reg        clear_allow
);
  // registered so peripherals see a stable permission across the access
  always @(posedge clock) begin
    if (!rstn) begin
      clear_allow <= 1'b1;
    end else begin
      clear_allow <= !in_break || clear_enable;
    end
  end
endmodule

// File: rtl/sim_break_lowpower.v
// Operation
// - break forces fetch to software vector
// - break without enable blocks flag clearing
// - flags cleared in break stay cleared
// - two-step clears protected until break ends
// - stop or wait clears interrupt mask
// - wait gates cpu clock, peripherals run
// - wait interrupt wakes, stacking next cycle
// - reset or break exits wait; flag set
// - watchdog runs in wait unless disabled
// - stop resets counter, disables all clocks
// - stop exit stacks after recovery time (break exit gives no stack_start)
// - recovery 4096 or 32 crystal cycles
// - counter held until recovery starts
// - three registers at fixed addresses
// - stop/wait break flag cleared by zero
// - reset sources flags, cleared by read
// - power-on sets own flag, clears others
// - illegal address only for opcode fetch
// - break clear enable read/write bit
`timescale 1ns/1ns
`include "sim_lowpower_defs.vh"
module sim_break_lowpower (
  input  wire        clock,
  input  wire        rstn,
  input  wire [15:0] addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  input  wire        break_request,
  input  wire        break_done,
  input  wire        stop_exec,
  input  wire        wait_exec,
  input  wire        irq_pending,
  input  wire        xclk_tick,
  input  wire        short_recovery_option,
  input  wire        watchdog_disable_option,
  input  wire        rst_power_on,
  input  wire        rst_pin,
  input  wire        rst_watchdog,
  input  wire        rst_illegal_opcode,
  input  wire        rst_illegal_addr,
  input  wire        illegal_addr_is_fetch,
  input  wire        rst_low_voltage,
  output reg         force_swi_vector,
  output reg  [15:0] vector_addr,
  output reg         in_break,
  output reg         clear_imask,
  output reg         cpu_clock_en,
  output reg         periph_clock_en,
  output reg         base_clock_output_en,
  output reg         crystal_clock_en,
  output reg         watchdog_run,
  output reg         stack_start,
  output reg         flag_clear_allow
);
  localparam RUN      = 2'd0;
  localparam WAITING  = 2'd1;
  localparam STOPPED  = 2'd2;
  localparam RECOVER  = 2'd3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg       exited_lowpower_reg;
  reg [7:0] reset_source_reg;
  reg       break_clear_enable_reg;
  reg       exit_by_break_reg;
  reg       exit_by_break_next;
  reg       por_seen_reg;
  wire      rec_done;
  wire      clear_allow_w;

  recovery_counter u_recovery (
    .clock     (clock),
    .rstn      (rstn),
    .hold      (state_reg != RECOVER),
    .xclk_tick (xclk_tick),
    .short_sel (short_recovery_option),
    .done      (rec_done)
  );

  flag_guard u_guard (
    .clock        (clock),
    .rstn         (rstn),
    .in_break     (in_break),
    .clear_enable (break_clear_enable_reg),
    .clear_allow  (clear_allow_w)
  );

  always @* begin
    state_next         = state_reg;
    exit_by_break_next = exit_by_break_reg;
    case (state_reg)
      RUN: begin
        exit_by_break_next = 1'b0;
        if (stop_exec) begin
          state_next = STOPPED;
        end else if (wait_exec) begin
          state_next = WAITING;
        end
      end
      WAITING: begin
        if (irq_pending || break_request) begin
          state_next         = RUN;
          exit_by_break_next = break_request;
        end
      end
      STOPPED: begin
        if (irq_pending || break_request) begin
          state_next         = RECOVER;
          exit_by_break_next = break_request;
        end
      end
      RECOVER: begin
        if (rec_done) begin
          state_next = RUN;
        end
      end
      default: state_next = RUN;
    endcase
  end

  always @(posedge clock) begin
    if (!rstn) begin
      state_reg         <= RUN;
      exit_by_break_reg <= 1'b0;
    end else begin
      state_reg         <= state_next;
      exit_by_break_reg <= exit_by_break_next;
    end
  end

  // clock gating and wake strobes, all registered
  always @(posedge clock) begin
    if (!rstn) begin
      cpu_clock_en         <= 1'b1;
      periph_clock_en      <= 1'b1;
      base_clock_output_en <= 1'b1;
      crystal_clock_en     <= 1'b1;
      watchdog_run         <= 1'b0;
      clear_imask          <= 1'b0;
      stack_start          <= 1'b0;
    end else begin
      cpu_clock_en         <= (state_next == RUN);
      periph_clock_en      <= (state_next == RUN) || (state_next == WAITING);
      // crystal restarts for recovery so the counter can time it
      base_clock_output_en <= (state_next == RUN) || (state_next == WAITING);
      crystal_clock_en     <= (state_next != STOPPED);
      watchdog_run         <= !watchdog_disable_option &&
                              ((state_next == RUN) || (state_next == WAITING));
      clear_imask          <= (state_reg == RUN) && (stop_exec || wait_exec);
      stack_start          <= ((state_reg == WAITING) && irq_pending && !break_request) ||
                              ((state_reg == RECOVER) && rec_done && !exit_by_break_reg);
    end
  end

  // break entry and vector forcing
  always @(posedge clock) begin
    if (!rstn) begin
      in_break         <= 1'b0;
      force_swi_vector <= 1'b0;
      vector_addr      <= 16'h0000;
    end else begin
      force_swi_vector <= break_request && !in_break;
      vector_addr      <= (break_request && !in_break) ? `SWI_VECTOR_ADDR : vector_addr;
      if (break_request && !in_break) begin
        in_break <= 1'b1;
      end else if (break_done) begin
        in_break <= 1'b0;
      end
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      flag_clear_allow <= 1'b1;
    end else begin
      flag_clear_allow <= clear_allow_w;
    end
  end

  // break stop/wait flag: set wins over a software clear
  always @(posedge clock) begin
    if (!rstn) begin
      exited_lowpower_reg <= 1'b0;
    end else if (((state_reg == WAITING) || (state_reg == STOPPED)) && break_request) begin
      exited_lowpower_reg <= 1'b1;
    end else if (wr && addr == `ADDR_BREAK_STATUS && !wdata[`BIT_BREAK_EXITED]) begin
      exited_lowpower_reg <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      break_clear_enable_reg <= 1'b0;
    end else if (wr && addr == `ADDR_BREAK_FLAG_CONTROL) begin
      break_clear_enable_reg <= wdata[`BIT_BREAK_CLEAR_ENABLE];
    end
  end

  // reset source flags are captured on every clock while reset is held low,
  // because the reset is synchronous and may load them from the cause inputs
  always @(posedge clock) begin
    if (!rstn) begin
      por_seen_reg <= 1'b1;
    end else begin
      por_seen_reg <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      reset_source_reg <= reset_source_reg;
      if (rst_power_on) begin
        reset_source_reg <= `POR_RESET_BYTE;
      end else begin
        if (rst_pin) begin
          reset_source_reg[`BIT_RST_PIN] <= 1'b1;
        end
        if (rst_watchdog) begin
          reset_source_reg[`BIT_RST_WATCHDOG] <= 1'b1;
        end
        if (rst_illegal_opcode) begin
          reset_source_reg[`BIT_RST_ILLEGAL_OPCODE] <= 1'b1;
        end
        if (rst_illegal_addr && illegal_addr_is_fetch) begin
          reset_source_reg[`BIT_RST_ILLEGAL_ADDR] <= 1'b1;
        end
        if (rst_low_voltage) begin
          reset_source_reg[`BIT_RST_LOW_VOLTAGE] <= 1'b1;
        end
      end
    end else if (rd && addr == `ADDR_RESET_SOURCE) begin
      reset_source_reg <= `RESET_BYTE;
    end
  end

  // read port; unmapped addresses including fe02 read zero
  always @(posedge clock) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ADDR_BREAK_STATUS:       rdata <= {6'h00, exited_lowpower_reg, 1'b0};
        `ADDR_RESET_SOURCE:       rdata <= {reset_source_reg[7:1], 1'b0};
        `ADDR_BREAK_FLAG_CONTROL: rdata <= {break_clear_enable_reg, 7'h00};
        default:                  rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// File: verif/crystal_osc_model.sv
`timescale 1ns/1ns
module crystal_osc_model (
  input  wire clock,
  input  wire rstn,
  input  wire crystal_clock_en,
  output reg  xclk_tick
);
  // crystal at half the bus rate, so recovery counts come out exact in bus cycles;
  // it stands still while the block has it switched off
  always @(posedge clock) begin
    if (!rstn || !crystal_clock_en) xclk_tick <= 1'b0;
    else xclk_tick <= ~xclk_tick;
  end
endmodule

// File: verif/sim_lowpower_chk.sv
`timescale 1ns/1ns
module sim_lowpower_chk (
  input wire        clock,
  input wire        rstn,
  input wire [15:0] addr,
  input wire        rd,
  input wire        stop_exec,
  input wire        wait_exec,
  input wire [7:0]  rdata,
  input wire        in_break,
  input wire        clear_imask,
  input wire        cpu_clock_en,
  input wire        periph_clock_en,
  input wire        base_clock_output_en,
  input wire        crystal_clock_en,
  input wire        flag_clear_allow,
  input wire        break_request,
  input wire        force_swi_vector,
  input wire [15:0] vector_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence rd_src; rd && addr == 16'hfe01; endsequence
  sequence lp_entry; stop_exec || wait_exec; endsequence
  a_imask_clear: assert property (lp_entry |=> clear_imask)
    else $error("mask not cleared");
  a_stop_clocks: assert property (stop_exec |=> !base_clock_output_en && !crystal_clock_en && !cpu_clock_en)
    else $error("clocks on in stop");
  a_wait_clocks: assert property (wait_exec |=> !cpu_clock_en && periph_clock_en)
    else $error("wait clock gating wrong");
  a_src_clear: assert property (rd_src ##2 rd_src |=> rdata == 8'h00)
    else $error("source flags not cleared by read");
  a_unmapped_zero: assert property (rd && addr == 16'hfe02 |=> rdata == 8'h00)
    else $error("unused address reads nonzero");
  a_ctrl_unused: assert property (rd && addr == 16'hfe03 |=> rdata[6:0] == 7'h00)
    else $error("control spare bits set");
  a_status_unused: assert property (rd && addr == 16'hfe00 |=> rdata[7:2] == 6'h00 && !rdata[0])
    else $error("status spare bits set");
  // permission passes two flops, so it trails the break state by two cycles
  a_guard_idle: assert property (!in_break |-> ##2 flag_clear_allow)
    else $error("clears blocked outside break");
  a_swi_force: assert property (break_request && !in_break |=> force_swi_vector && vector_addr == 16'hfffc)
    else $error("break did not force software vector");
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  reg         clock = 1'b0;
  reg         rstn = 1'b0;
  reg  [15:0] addr = 16'h0000;
  reg  [7:0]  wdata = 8'h00;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         break_request = 1'b0;
  reg         break_done = 1'b0;
  reg         stop_exec = 1'b0;
  reg         wait_exec = 1'b0;
  reg         irq_pending = 1'b0;
  reg         short_opt = 1'b0;
  reg         wd_dis = 1'b0;
  reg  [6:0]  cause = 7'h01;
  reg  [15:0] d;
  wire        xclk_tick;
  wire [7:0]  rdata;
  wire [15:0] vector_addr;
  wire        force_swi_vector, in_break, clear_imask, cpu_clock_en, periph_clock_en;
  wire        base_clock_output_en, crystal_clock_en, watchdog_run, stack_start, flag_clear_allow;
  integer     error_cnt = 0;
  integer     n_tests = 0;
  integer     cyc = 0;
  integer     n;
  localparam [39:0] SRC = 40'h40_1008_0402;
  crystal_osc_model osc (.clock(clock), .rstn(rstn), .crystal_clock_en(crystal_clock_en), .xclk_tick(xclk_tick));
  sim_break_lowpower DUT (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .break_request(break_request), .break_done(break_done), .stop_exec(stop_exec),
    .wait_exec(wait_exec), .irq_pending(irq_pending), .xclk_tick(xclk_tick), .short_recovery_option(short_opt),
    .watchdog_disable_option(wd_dis), .rst_power_on(cause[0]), .rst_pin(cause[1]), .rst_watchdog(cause[2]),
    .rst_illegal_opcode(cause[3]), .rst_illegal_addr(cause[4]), .illegal_addr_is_fetch(cause[6]),
    .rst_low_voltage(cause[5]), .force_swi_vector(force_swi_vector), .vector_addr(vector_addr),
    .in_break(in_break), .clear_imask(clear_imask), .cpu_clock_en(cpu_clock_en),
    .periph_clock_en(periph_clock_en), .base_clock_output_en(base_clock_output_en),
    .crystal_clock_en(crystal_clock_en), .watchdog_run(watchdog_run), .stack_start(stack_start),
    .flag_clear_allow(flag_clear_allow));
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_rng(input integer v, input integer lo, input integer hi);
    begin
      n_tests = n_tests + 1;
      if (v < lo || v > hi) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t cycle count %0d outside %0d..%0d", $time, v, lo, hi);
      end
    end
  endtask
  task wr_reg(input [15:0] a, input [7:0] v);
    begin
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [15:0] a);
    begin
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = {8'h00, rdata};
    end
  endtask
  task rst_with(input [6:0] c);
    begin
      @(posedge clock);
      cause <= c;
      rstn <= 1'b0;
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
    end
  endtask
  // sel 1 waits for cpu clocks back (break exit has no stacking)
  task wait_on(input integer lim, input sel);
    begin
      n = 0;
      while ((sel ? cpu_clock_en : stack_start) !== 1'b1 && n < lim) begin
        @(posedge clock);
        #1 n = n + 1;
      end
    end
  endtask
  task t_regs;
    begin
      rd_reg(16'hfe01); chk(d, 16'h0080);
      rd_reg(16'hfe01); chk(d, 16'h0000);
      rd_reg(16'hfe00); chk(d, 16'h0000);
      wr_reg(16'hfe02, 8'hff); rd_reg(16'hfe02); chk(d, 16'h0000);
      wr_reg(16'hfe03, 8'hff); rd_reg(16'hfe03); chk(d, 16'h0080);
      $display("t_regs done");
    end
  endtask
  task t_wait;
    begin
      wd_dis <= 1'b1;
      repeat (2) @(posedge clock);
      #1 chk({15'h0000, watchdog_run}, 16'h0000);
      wd_dis <= 1'b0;
      @(posedge clock);
      wait_exec <= 1'b1;
      @(posedge clock);
      wait_exec <= 1'b0;
      #1 chk({15'h0000, clear_imask}, 16'h0001);
      repeat (3) @(posedge clock);
      #1 chk({13'h0000, cpu_clock_en, periph_clock_en, watchdog_run}, 16'h0003);
      irq_pending <= 1'b1;
      wait_on(8, 1'b0);
      chk_rng(n, 1, 2);
      @(posedge clock);
      irq_pending <= 1'b0;
      $display("t_wait done");
    end
  endtask
  task t_stop(input sh, input brk, input integer lo, input integer hi);
    begin
      if (brk) wr_reg(16'hfe03, 8'h00);
      @(posedge clock);
      short_opt <= sh;
      stop_exec <= 1'b1;
      @(posedge clock);
      stop_exec <= 1'b0;
      #1 chk({12'h000, cpu_clock_en, base_clock_output_en, crystal_clock_en, periph_clock_en}, 16'h0000);
      repeat (5) @(posedge clock);
      if (brk) break_request <= 1'b1;
      else irq_pending <= 1'b1;
      wait_on(9000, brk);
      chk_rng(n, lo, hi);
      @(posedge clock);
      irq_pending <= 1'b0;
      if (brk) begin
        chk(vector_addr, 16'hfffc);
        chk({14'h0000, in_break, flag_clear_allow}, 16'h0002);
        rd_reg(16'hfe00); chk(d, 16'h0002);
        wr_reg(16'hfe03, 8'h80); repeat (2) @(posedge clock);
        #1 chk({15'h0000, flag_clear_allow}, 16'h0001);
        break_request <= 1'b0;
        break_done <= 1'b1;
        @(posedge clock);
        break_done <= 1'b0;
        wr_reg(16'hfe00, 8'h00); rd_reg(16'hfe00); chk(d, 16'h0000);
      end
      $display("t_stop done");
    end
  endtask
  task t_sources;
    integer i;
    begin
      for (i = 1; i < 6; i = i + 1) begin
        rst_with(i == 4 ? 7'h50 : 7'h01 << i);
        rd_reg(16'hfe01); chk(d, {8'h00, SRC[8*(5-i) +: 8]});
      end
      rst_with(7'h10); rd_reg(16'hfe01); chk(d, 16'h0000);
      $display("t_sources done");
    end
  endtask
  initial begin
    rst_with(7'h01);
    t_regs;
    t_wait;
    t_stop(1'b1, 1'b0, 60, 72);
    t_stop(1'b0, 1'b0, 8188, 8200);
    t_stop(1'b1, 1'b1, 60, 72);
    t_sources;
    wrap_up;
  end
endmodule
bind sim_break_lowpower sim_lowpower_chk u_chk (.clock(clock), .rstn(rstn), .addr(addr), .rd(rd),
  .stop_exec(stop_exec), .wait_exec(wait_exec), .rdata(rdata), .in_break(in_break), .clear_imask(clear_imask),
  .cpu_clock_en(cpu_clock_en), .periph_clock_en(periph_clock_en), .base_clock_output_en(base_clock_output_en),
  .crystal_clock_en(crystal_clock_en), .flag_clear_allow(flag_clear_allow), .break_request(break_request),
  .force_swi_vector(force_swi_vector), .vector_addr(vector_addr));
